// *** hdl/irq_bank_pkg.sv ***
// package: constants and types of the peripheral interrupt enable bank
// assumes: 8-bit register port and a single core clock
package irq_bank_pkg;

  // ****************************************
  // sizes and types
  // ****************************************
  localparam int NUM_BANKS = 5;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;
  typedef logic [DATA_W-1:0] byte_type;
  typedef logic [ADDR_W-1:0] addr_type;
  typedef logic [NUM_BANKS-1:0][DATA_W-1:0] bank_type;

  // ****************************************
  // register offsets
  // ****************************************
  localparam addr_type OFS_ENABLE_1 = 4'h0;
  localparam addr_type OFS_ENABLE_5 = 4'h4;
  localparam addr_type OFS_CTRL = 4'h5;
  localparam addr_type OFS_FLAGS_1 = 4'h6;
  localparam addr_type OFS_FLAGS_5 = 4'ha;
  localparam addr_type OFS_STATUS = 4'hb;

  // ****************************************
  // reset values and implemented bits
  // ****************************************
  localparam byte_type RESET_VALUE = 8'h00;
  localparam byte_type CTRL_MASK = 8'hc0;
  localparam bank_type WRITE_MASK = {8'hf7, 8'h3f, 8'h3f, 8'h43, 8'hc3};

  // ****************************************
  // field positions
  // ****************************************
  localparam int OSC_FAIL_IRQ_EN = 7, CLK_SWITCH_DONE_IRQ_EN = 6;
  localparam int CONV_THRESHOLD_IRQ_EN = 1, CONV_DONE_IRQ_EN = 0;
  localparam int ZERO_CROSS_IRQ_EN = 6, COMPARATOR2_IRQ_EN = 1, COMPARATOR1_IRQ_EN = 0;
  localparam int SERIAL_RX_IRQ_EN = 5, SERIAL_TX_IRQ_EN = 4;
  localparam int SYNC_PORT2_COLLISION_IRQ_EN = 3, SYNC_PORT2_IRQ_EN = 2;
  localparam int SYNC_PORT1_COLLISION_IRQ_EN = 1, SYNC_PORT1_IRQ_EN = 0;
  localparam int TIMER6_MATCH_IRQ_EN = 5, TIMER4_MATCH_IRQ_EN = 3, TIMER2_MATCH_IRQ_EN = 1;
  localparam int TIMER5_OVERFLOW_IRQ_EN = 4, TIMER3_OVERFLOW_IRQ_EN = 2, TIMER1_OVERFLOW_IRQ_EN = 0;
  localparam int LOGIC_CELL4_IRQ_EN = 7, LOGIC_CELL1_IRQ_EN = 4, UNUSED_BANK5_BIT = 3;
  localparam int LOGIC_CELL3_IRQ_EN = 6, LOGIC_CELL2_IRQ_EN = 5;
  localparam int TIMER5_GATE_IRQ_EN = 2, TIMER3_GATE_IRQ_EN = 1, TIMER1_GATE_IRQ_EN = 0;
  localparam int GLOBAL_IRQ_EN = 7, PERIPHERAL_IRQ_MASTER_EN = 6;
  localparam int STATUS_ANY_PENDING = 0, STATUS_REQUEST = 1;

  // bank index of an address within a run of five registers
  function automatic logic [2:0] bank_sel(input addr_type a, input addr_type base);
    bank_sel = 3'(a - base);
  endfunction

endpackage

// *** hdl/irq_bank_if.sv ***
// interface: enables, flags and merged request between bank modules
// assumes: all signals on core_clk, driven by one side each
`timescale 1ns/100ps
interface irq_bank_if;
  irq_bank_pkg::bank_type enables;
  irq_bank_pkg::bank_type flags;
  irq_bank_pkg::bank_type pending;
  logic                   master_en;
  logic                   global_en;
  logic                   request;

  modport store (output enables);
  modport merge (input enables, input flags, input master_en, input global_en,
                 output pending, output request);
  modport top   (input enables, output flags, output master_en, output global_en,
                 input pending, input request);
endinterface

// *** hdl/irq_enable_store.sv ***
// module: the five enable registers with their implemented-bit masks
// assumes: write strobe is one cycle, address already checked by nobody
`timescale 1ns/100ps
module irq_enable_store (
  input  wire logic                   wr_en,
  input  wire irq_bank_pkg::addr_type wr_addr,
  input  wire irq_bank_pkg::byte_type wr_data,
  input  wire logic                   core_clk,
  input  wire logic                   sys_rst,
  irq_bank_if.store                   bank
);

  irq_bank_pkg::bank_type enables_q;
  logic                   hit;
  logic [2:0]             idx;

  // ****************************************
  // decode and storage
  // ****************************************
  assign hit = wr_en && (wr_addr <= irq_bank_pkg::OFS_ENABLE_5);
  assign idx = irq_bank_pkg::bank_sel(wr_addr, irq_bank_pkg::OFS_ENABLE_1);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      enables_q <= {irq_bank_pkg::NUM_BANKS{irq_bank_pkg::RESET_VALUE}};
    end else if (hit) begin
      // unimplemented bits never store, so they read back as zero
      enables_q[idx] <= wr_data & irq_bank_pkg::WRITE_MASK[idx];
    end
  end

  assign bank.enables = enables_q;

  // ****************************************
  // checks
  // ****************************************
  chk_unused_bits: assert property (@(posedge core_clk) disable iff (sys_rst)
    (enables_q & ~irq_bank_pkg::WRITE_MASK) == '0)
    else $error("unimplemented enable bit is set");

  chk_write_lands: assert property (@(posedge core_clk) disable iff (sys_rst)
    hit |=> enables_q[$past(idx)] == ($past(wr_data) & irq_bank_pkg::WRITE_MASK[$past(idx)]))
    else $error("enable write did not land");

endmodule

// *** hdl/irq_request_merge.sv ***
// module: per-source gating and the merged peripheral request
// assumes: flags come from logic on core_clk, so no synchroniser
`timescale 1ns/100ps
module irq_request_merge (
  irq_bank_if.merge bank
);

  // ****************************************
  // gating
  // ****************************************
  always_comb begin
    bank.pending    = '0;
    bank.pending[0] = bank.flags[0] & bank.enables[0];
    bank.pending[1] = bank.flags[1] & bank.enables[1];
    bank.pending[2] = bank.flags[2] & bank.enables[2];
    bank.pending[3] = bank.flags[3] & bank.enables[3];
    bank.pending[4] = bank.flags[4] & bank.enables[4];
  end

  // nothing from this bank passes without both master enables
  always_comb begin
    bank.request = (|bank.pending) & bank.master_en & bank.global_en;
  end

endmodule

// *** hdl/peripheral_irq_enable_bank.sv ***
// module: top of the peripheral interrupt enable bank with register port
// assumes: one 10 MHz core clock, flag sources and core on that clock
`timescale 1ns/100ps

module peripheral_irq_enable_bank (
  input  wire logic                   core_clk,
  input  wire logic                   sys_rst,
  input  wire irq_bank_pkg::addr_type reg_addr,
  input  wire irq_bank_pkg::byte_type reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output      irq_bank_pkg::byte_type reg_rdata,
  input  wire irq_bank_pkg::bank_type periph_flags,
  output      logic                   irq_request
);

  // ****************************************
  // declarations
  // ****************************************
  irq_bank_if bank_if ();

  irq_bank_pkg::byte_type ctrl_q;
  irq_bank_pkg::byte_type rd_data_q;
  irq_bank_pkg::byte_type rd_data_d;
  irq_bank_pkg::byte_type status;
  logic                   irq_q;
  logic                   any_pending;
  logic [2:0]             rd_idx;
  logic [2:0]             flag_idx;

  // ****************************************
  // sub-blocks
  // ****************************************
  irq_enable_store u_store (
    .wr_en    (reg_wr),
    .wr_addr  (reg_addr),
    .wr_data  (reg_wdata),
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .bank     (bank_if.store)
  );

  irq_request_merge u_merge (
    .bank (bank_if.merge)
  );

  // raw flags pass in untouched; only the merge masks them, with the enables
  assign bank_if.flags     = periph_flags;
  assign bank_if.master_en = ctrl_q[irq_bank_pkg::PERIPHERAL_IRQ_MASTER_EN];
  assign bank_if.global_en = ctrl_q[irq_bank_pkg::GLOBAL_IRQ_EN];

  // ****************************************
  // control register
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_q <= irq_bank_pkg::RESET_VALUE;
    end else if (reg_wr && reg_addr == irq_bank_pkg::OFS_CTRL) begin
      ctrl_q <= reg_wdata & irq_bank_pkg::CTRL_MASK;
    end
  end

  // ****************************************
  // read port
  // ****************************************
  assign rd_idx      = irq_bank_pkg::bank_sel(reg_addr, irq_bank_pkg::OFS_ENABLE_1);
  assign flag_idx    = irq_bank_pkg::bank_sel(reg_addr, irq_bank_pkg::OFS_FLAGS_1);
  assign any_pending = |bank_if.pending;

  always_comb begin
    status = irq_bank_pkg::RESET_VALUE;
    status[irq_bank_pkg::STATUS_ANY_PENDING] = any_pending;
    status[irq_bank_pkg::STATUS_REQUEST]     = irq_q;
  end

  // unmapped addresses and idle cycles return zero
  always_comb begin
    rd_data_d = irq_bank_pkg::RESET_VALUE;
    if (reg_rd) begin
      if (reg_addr <= irq_bank_pkg::OFS_ENABLE_5) begin
        rd_data_d = bank_if.enables[rd_idx];
      end else if (reg_addr == irq_bank_pkg::OFS_CTRL) begin
        rd_data_d = ctrl_q;
      end else if (reg_addr >= irq_bank_pkg::OFS_FLAGS_1 && reg_addr <= irq_bank_pkg::OFS_FLAGS_5) begin
        rd_data_d = periph_flags[flag_idx];
      end else if (reg_addr == irq_bank_pkg::OFS_STATUS) begin
        rd_data_d = status;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rd_data_q <= irq_bank_pkg::RESET_VALUE;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  assign reg_rdata = rd_data_q;

  // ****************************************
  // request to the core
  // ****************************************
  // registered so the core sees a clean level; costs one cycle of latency
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= bank_if.request;
    end
  end

  assign irq_request = irq_q;

  // ****************************************
  // assertion helpers
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking

  default disable iff (sys_rst);

  function automatic irq_bank_pkg::bank_type src_only(input int k, input int b);
    irq_bank_pkg::bank_type v;
    v = '0;
    v[k][b] = 1'b1;
    return v;
  endfunction

  logic gates_on;
  assign gates_on = bank_if.master_en && bank_if.global_en;

  sequence s_write(irq_bank_pkg::addr_type a);
    reg_wr && reg_addr == a;
  endsequence

  sequence s_read(irq_bank_pkg::addr_type a);
    reg_rd && reg_addr == a;
  endsequence

  sequence s_lone_source(int k, int b);
    periph_flags == src_only(k, b) && gates_on;
  endsequence

  // a lone flag reaches the core exactly when its own enable is set
  property p_bit_gate(int k, int b);
    s_lone_source(k, b) |=> irq_request == $past(bank_if.enables[k][b]);
  endproperty

  // ****************************************
  // checks per source
  // ****************************************
  chk_osc_fail_gate: assert property (p_bit_gate(0, irq_bank_pkg::OSC_FAIL_IRQ_EN))
    else $error("oscillator fail gating wrong");

  chk_clk_switch_gate: assert property (p_bit_gate(0, irq_bank_pkg::CLK_SWITCH_DONE_IRQ_EN))
    else $error("clock switch gating wrong");

  chk_conv_thr_gate: assert property (p_bit_gate(0, irq_bank_pkg::CONV_THRESHOLD_IRQ_EN))
    else $error("converter threshold gating wrong");

  chk_conv_done_gate: assert property (p_bit_gate(0, irq_bank_pkg::CONV_DONE_IRQ_EN))
    else $error("converter done gating wrong");

  chk_zero_cross_gate: assert property (p_bit_gate(1, irq_bank_pkg::ZERO_CROSS_IRQ_EN))
    else $error("zero cross gating wrong");

  chk_comp2_gate: assert property (p_bit_gate(1, irq_bank_pkg::COMPARATOR2_IRQ_EN))
    else $error("comparator two gating wrong");

  chk_comp1_gate: assert property (p_bit_gate(1, irq_bank_pkg::COMPARATOR1_IRQ_EN))
    else $error("comparator one gating wrong");

  chk_serial_rx_gate: assert property (p_bit_gate(2, irq_bank_pkg::SERIAL_RX_IRQ_EN))
    else $error("serial receive gating wrong");

  chk_serial_tx_gate: assert property (p_bit_gate(2, irq_bank_pkg::SERIAL_TX_IRQ_EN))
    else $error("serial transmit gating wrong");

  chk_port2_coll_gate: assert property (p_bit_gate(2, irq_bank_pkg::SYNC_PORT2_COLLISION_IRQ_EN))
    else $error("port two collision gating wrong");

  chk_port2_xfer_gate: assert property (p_bit_gate(2, irq_bank_pkg::SYNC_PORT2_IRQ_EN))
    else $error("port two transfer gating wrong");

  chk_port1_coll_gate: assert property (p_bit_gate(2, irq_bank_pkg::SYNC_PORT1_COLLISION_IRQ_EN))
    else $error("port one collision gating wrong");

  chk_port1_xfer_gate: assert property (p_bit_gate(2, irq_bank_pkg::SYNC_PORT1_IRQ_EN))
    else $error("port one transfer gating wrong");

  chk_t6_match_gate: assert property (p_bit_gate(3, irq_bank_pkg::TIMER6_MATCH_IRQ_EN))
    else $error("timer six match gating wrong");

  chk_t4_match_gate: assert property (p_bit_gate(3, irq_bank_pkg::TIMER4_MATCH_IRQ_EN))
    else $error("timer four match gating wrong");

  chk_t2_match_gate: assert property (p_bit_gate(3, irq_bank_pkg::TIMER2_MATCH_IRQ_EN))
    else $error("timer two match gating wrong");

  chk_t5_ovf_gate: assert property (p_bit_gate(3, irq_bank_pkg::TIMER5_OVERFLOW_IRQ_EN))
    else $error("timer five overflow gating wrong");

  chk_t3_ovf_gate: assert property (p_bit_gate(3, irq_bank_pkg::TIMER3_OVERFLOW_IRQ_EN))
    else $error("timer three overflow gating wrong");

  chk_t1_ovf_gate: assert property (p_bit_gate(3, irq_bank_pkg::TIMER1_OVERFLOW_IRQ_EN))
    else $error("timer one overflow gating wrong");

  chk_cell4_gate: assert property (p_bit_gate(4, irq_bank_pkg::LOGIC_CELL4_IRQ_EN))
    else $error("logic cell four gating wrong");

  chk_cell3_gate: assert property (p_bit_gate(4, irq_bank_pkg::LOGIC_CELL3_IRQ_EN))
    else $error("logic cell three gating wrong");

  chk_cell2_gate: assert property (p_bit_gate(4, irq_bank_pkg::LOGIC_CELL2_IRQ_EN))
    else $error("logic cell two gating wrong");

  chk_cell1_gate: assert property (p_bit_gate(4, irq_bank_pkg::LOGIC_CELL1_IRQ_EN))
    else $error("logic cell one gating wrong");

  chk_t5_gate_gate: assert property (p_bit_gate(4, irq_bank_pkg::TIMER5_GATE_IRQ_EN))
    else $error("timer five gate gating wrong");

  chk_t3_gate_gate: assert property (p_bit_gate(4, irq_bank_pkg::TIMER3_GATE_IRQ_EN))
    else $error("timer three gate gating wrong");

  chk_t1_gate_gate: assert property (p_bit_gate(4, irq_bank_pkg::TIMER1_GATE_IRQ_EN))
    else $error("timer one gate gating wrong");

  // the absent bit can never raise a request
  chk_bank5_hole: assert property (
    periph_flags == src_only(4, irq_bank_pkg::UNUSED_BANK5_BIT) |=> !irq_request)
    else $error("absent bank five bit raised a request");

  // ****************************************
  // checks on enables and master bits
  // ****************************************
  chk_master_blocks: assert property (
    !bank_if.master_en |=> !irq_request)
    else $error("request without peripheral master enable");

  chk_master_position: assert property (
    s_write(irq_bank_pkg::OFS_CTRL) |=>
      bank_if.master_en == $past(reg_wdata[irq_bank_pkg::PERIPHERAL_IRQ_MASTER_EN]))
    else $error("master enable not at control bit six");

  chk_global_blocks: assert property (
    !bank_if.global_en ##1 1'b1 |-> !irq_request)
    else $error("request without global enable");

  chk_merge_exact: assert property (
    1'b1 |=> irq_request == $past((|(periph_flags & bank_if.enables)) && gates_on))
    else $error("request differs from gated flag merge");

  chk_reset_clears: assert property (@(posedge core_clk) disable iff (1'b0)
    sys_rst |=> bank_if.enables == '0 && ctrl_q == '0 && !irq_request && reg_rdata == '0)
    else $error("reset left an enable or output set");

  // ****************************************
  // checks on the read port
  // ****************************************
  sequence s_write_then_read;
    s_write(irq_bank_pkg::OFS_ENABLE_1) ##1 s_read(irq_bank_pkg::OFS_ENABLE_1);
  endsequence

  chk_enable_readback: assert property (
    s_write_then_read |=> reg_rdata == ($past(reg_wdata, 2) & irq_bank_pkg::WRITE_MASK[0]))
    else $error("enable readback not masked write value");

  chk_unused_read_zero: assert property (
    reg_rd && reg_addr <= irq_bank_pkg::OFS_ENABLE_5 |=>
      (reg_rdata & ~irq_bank_pkg::WRITE_MASK[$past(rd_idx)]) == '0)
    else $error("unimplemented bit read nonzero");

  chk_flag_view_raw: assert property (
    s_read(irq_bank_pkg::OFS_FLAGS_1) |=> reg_rdata == $past(periph_flags[0]))
    else $error("flag view not raw flags");

  chk_read_one_cycle: assert property (
    !reg_rd |=> reg_rdata == '0)
    else $error("read data outside its cycle");

  // unmapped space reads as zero so software may probe it safely
  chk_unmapped_read_zero: assert property (
    reg_rd && reg_addr > irq_bank_pkg::OFS_STATUS |=> reg_rdata == '0)
    else $error("unmapped read returned data");

  // every flag bank, not only the first, shows its raw levels
  chk_flag_view_bank: assert property (
    reg_rd && reg_addr >= irq_bank_pkg::OFS_FLAGS_1 && reg_addr <= irq_bank_pkg::OFS_FLAGS_5 |=>
      reg_rdata == $past(periph_flags[reg_addr - irq_bank_pkg::OFS_FLAGS_1]))
    else $error("flag view not raw flags of its bank");

  // status shows the cycle of the read, not the one after
  chk_status_view: assert property (
    s_read(irq_bank_pkg::OFS_STATUS) |=>
      reg_rdata == {6'h00, $past(irq_request), $past(|(periph_flags & bank_if.enables))})
    else $error("status view wrong");

  // ****************************************
  // checks on control and holding
  // ****************************************
  // a stray write elsewhere must never disturb a stored enable
  chk_enables_hold: assert property (
    !(reg_wr && reg_addr <= irq_bank_pkg::OFS_ENABLE_5) |=> $stable(bank_if.enables))
    else $error("enable changed without a write");

  chk_ctrl_hold: assert property (
    !(reg_wr && reg_addr == irq_bank_pkg::OFS_CTRL) |=> $stable(ctrl_q))
    else $error("control changed without a write");

  chk_ctrl_unused_zero: assert property (
    (ctrl_q & ~irq_bank_pkg::CTRL_MASK) == '0)
    else $error("unimplemented control bit is set");

  chk_global_position: assert property (
    s_write(irq_bank_pkg::OFS_CTRL) |=>
      bank_if.global_en == $past(reg_wdata[irq_bank_pkg::GLOBAL_IRQ_EN]))
    else $error("global enable not at control bit seven");

  sequence s_ctrl_write_then_read;
    s_write(irq_bank_pkg::OFS_CTRL) ##1 s_read(irq_bank_pkg::OFS_CTRL);
  endsequence

  chk_ctrl_readback: assert property (
    s_ctrl_write_then_read |=> reg_rdata == ($past(reg_wdata, 2) & irq_bank_pkg::CTRL_MASK))
    else $error("control readback not masked write value");

endmodule

// *** test/flag_source_model.sv ***
// partner: peripheral flag sources feeding the enable bank
// assumes: set and clear masks driven on core_clk by the bench
`timescale 1ns/100ps
module flag_source_model (
  input  wire logic                   core_clk,
  input  wire logic                   sys_rst,
  input  wire irq_bank_pkg::bank_type flag_set,
  input  wire irq_bank_pkg::bank_type flag_clr,
  output      irq_bank_pkg::bank_type flags
);
  // ****************
  // flag state
  // ****************
  irq_bank_pkg::bank_type flags_q;

  // set wins over clear so a peripheral event is never lost
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~flag_clr) | flag_set;
    end
  end

  assign flags = flags_q;
endmodule

// *** test/peripheral_irq_enable_bank_tb_top.sv ***
// bench: register port, per-bit gating and random traffic on the enable bank
// assumes: one 10 MHz clock, flag sources modelled by flag_source_model
`timescale 1ns/100ps
`define CHECK(got, exp, what) begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
  $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp); end end
module peripheral_irq_enable_bank_tb_top;
  // ****************
  // signals
  // ****************
  logic                   core_clk = 1'b0;
  logic                   sys_rst;
  irq_bank_pkg::addr_type reg_addr;
  irq_bank_pkg::byte_type reg_wdata;
  logic                   reg_wr;
  logic                   reg_rd;
  irq_bank_pkg::byte_type reg_rdata;
  irq_bank_pkg::bank_type periph_flags;
  logic                   irq_request;
  irq_bank_pkg::bank_type flag_set;
  irq_bank_pkg::bank_type flag_clr;
  irq_bank_pkg::bank_type shadow_en;
  irq_bank_pkg::bank_type hot;
  irq_bank_pkg::byte_type shadow_ctrl;
  irq_bank_pkg::byte_type m;
  irq_bank_pkg::byte_type c;
  logic                   exp_irq;
  int                     miscompares = 0;
  int                     comparisons = 0;
  int                     k;
  int                     b;

  always #50 core_clk = ~core_clk;

  peripheral_irq_enable_bank dut (
    .core_clk     (core_clk),
    .sys_rst      (sys_rst),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_wr       (reg_wr),
    .reg_rd       (reg_rd),
    .reg_rdata    (reg_rdata),
    .periph_flags (periph_flags),
    .irq_request  (irq_request)
  );

  flag_source_model partner (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .flag_set (flag_set),
    .flag_clr (flag_clr),
    .flags    (periph_flags)
  );

  // ****************
  // expectations
  // ****************
  function automatic irq_bank_pkg::byte_type impl_bits(input int idx);
    case (idx)
      0: impl_bits = 8'hc3;
      1: impl_bits = 8'h43;
      2: impl_bits = 8'h3f;
      3: impl_bits = 8'h3f;
      default: impl_bits = 8'hf7;
    endcase
  endfunction

  // shadow of the enables, updated at the same edge as the registers
  always @(posedge core_clk) begin
    if (sys_rst) begin
      shadow_en <= '0;
      shadow_ctrl <= 8'h00;
      exp_irq <= 1'b0;
    end else begin
      if (reg_wr && reg_addr < 4'h5) shadow_en[reg_addr] <= reg_wdata & impl_bits(int'(reg_addr));
      if (reg_wr && reg_addr == 4'h5) shadow_ctrl <= reg_wdata & 8'hc0;
      exp_irq <= (|(periph_flags & shadow_en)) & shadow_ctrl[7] & shadow_ctrl[6];
    end
  end

  // request checked every cycle, one cycle behind its causes
  always @(negedge core_clk) if (!sys_rst) `CHECK(irq_request, exp_irq, "request")

  // ****************
  // bus and flag tasks
  // ****************
  task automatic reg_write(input irq_bank_pkg::addr_type a, input irq_bank_pkg::byte_type d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic expect_reg(input irq_bank_pkg::addr_type a, input irq_bank_pkg::byte_type e, input string what);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 `CHECK(reg_rdata, e, what)
    // read data stands one cycle only
    @(posedge core_clk);
    #1 `CHECK(reg_rdata, 8'h00, "read data after its cycle")
  endtask

  // write and read back with no gap between the strobes
  task automatic write_read(input irq_bank_pkg::addr_type a, input irq_bank_pkg::byte_type d,
                            input irq_bank_pkg::byte_type e, input string what);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 `CHECK(reg_rdata, e, what)
  endtask

  task automatic flags_to(input irq_bank_pkg::bank_type v);
    @(posedge core_clk);
    flag_set <= v;
    flag_clr <= ~v;
    @(posedge core_clk);
    flag_set <= '0;
    flag_clr <= '0;
  endtask

  task automatic complete_run;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************
  // sequence
  // ****************
  initial begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    complete_run();
  end

  initial begin
    sys_rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    flag_set = '0;
    flag_clr = '0;
    void'($urandom(32'h36866171));
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (k = 0; k < 5; k++) expect_reg(4'(k), 8'h00, "enable after reset");
    expect_reg(4'h5, 8'h00, "control after reset");
    // all ones: only implemented bits may stick
    for (k = 0; k < 5; k++) begin
      reg_write(4'(k), 8'hff);
      expect_reg(4'(k), impl_bits(k), "implemented bits");
    end
    reg_write(4'h5, 8'hff);
    expect_reg(4'h5, 8'hc0, "control bits");
    // stray writes to read-only and unmapped places
    reg_write(4'hb, 8'h00);
    reg_write(4'h6, 8'hff);
    reg_write(4'hc, 8'hff);
    expect_reg(4'hc, 8'h00, "unmapped read");
    expect_reg(4'h0, 8'hc3, "enable after stray writes");
    write_read(4'h0, 8'h5a, 8'h42, "enable write then read");
    for (k = 0; k < 5; k++) reg_write(4'(k), 8'h00);
    write_read(4'h5, 8'hff, 8'hc0, "control write then read");
    // each enable bit passes only its own flag
    for (k = 0; k < 5; k++) begin
      m = impl_bits(k);
      for (b = 0; b < 8; b++) begin
        hot = '0;
        hot[k][b] = 1'b1;
        reg_write(4'(k), 8'h01 << b);
        flags_to(hot);
        @(posedge core_clk);
        #1 `CHECK(irq_request, m[b], "own flag")
        flags_to(~hot);
        @(posedge core_clk);
        #1 `CHECK(irq_request, 1'b0, "foreign flags")
        reg_write(4'(k), 8'h00);
      end
    end
    // both control bits are needed; hazard is a single-bit gate
    reg_write(4'h0, 8'hc3);
    flags_to('1);
    for (b = 0; b < 4; b++) begin
      c = 8'(b) << 6;
      reg_write(4'h5, c);
      @(posedge core_clk);
      #1 `CHECK(irq_request, (c == 8'hc0), "control gating")
    end
    expect_reg(4'hb, 8'h03, "status view");
    reg_write(4'h0, 8'h00);
    expect_reg(4'h6, 8'hff, "raw flag view");
    // random traffic; the request monitor runs throughout
    for (k = 0; k < 40; k++) begin
      reg_write(4'($urandom % 6), 8'($urandom));
      flags_to(irq_bank_pkg::bank_type'({$urandom, $urandom}));
      b = $urandom % 5;
      expect_reg(4'(b), shadow_en[b], "random enable");
      expect_reg(4'(b + 6), periph_flags[b], "random flag view");
      m = 8'($urandom);
      write_read(4'(b), m, m & impl_bits(b), "random write then read");
    end
    // a reset in mid-run clears enables and control once more
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (k = 0; k < 6; k++) expect_reg(4'(k), 8'h00, "register after mid-run reset");
    complete_run();
  end
endmodule
